// File: bsc_monitor.sv
// Purpose: Port checks for the buck start-up block
// Assumes: One clock, async active-low reset
// Notes: Bound to every instance
`timescale 1ns/10ps
module bsc_monitor
	import bsc_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic [bsc_pkg::DATA_W-1:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [4:0] seq_slot_reached,
	input wire logic hw_enable1,
	input wire logic hw_enable2,
	input wire logic [1:0] buck_enable,
	input wire logic [1:0][bsc_pkg::CODE_W-1:0] buck_target_code,
	input wire logic [1:0][bsc_pkg::MV_W-1:0] buck_target_mv,
	input wire logic [1:0] buck_limit_violation
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// ----
	// Bus handshake and decode
	// ----
	a_ready_after_setup: assert property (psel && !penable |=> pready) else $error("no ready after setup");
	a_ready_one_cycle: assert property (pready |=> !pready) else $error("ready too long");
	a_err_with_ready: assert property (pslverr |-> pready) else $error("error without ready");
	a_rdata_quiet: assert property (!pready |-> prdata == '0) else $error("read data outside answer");
	a_no_source_off: assert property ($past(presetn) && $past(seq_slot_reached) == 5'h00 &&
		!$past(hw_enable1) && !$past(hw_enable2) |-> buck_enable == 2'h0) else $error("enable without source");
	for (genvar i = 0; i < 2; i++) begin : g_conv
		a_code_low_zero: assert property (buck_target_code[i][1:0] == 2'h0) else $error("low code bits set");
		a_mv_floor: assert property ($past(presetn) && buck_target_code[i] <= CODE_FLOOR
			|-> buck_target_mv[i] == 11'h258) else $error("floor voltage wrong");
		a_mv_step: assert property ($past(presetn) && buck_target_code[i] > CODE_FLOOR && buck_target_code[i] < CODE_CEIL
			|-> buck_target_mv[i] == 11'(600 + (int'(buck_target_code[i]) - 8) * 25 / 2)) else $error("step voltage wrong");
		a_mv_ceiling: assert property (buck_target_code[i] >= CODE_CEIL |-> buck_target_mv[i] == 11'h708)
			else $error("ceiling voltage wrong");
		a_limit_above_cap: assert property (buck_limit_violation[i] |-> buck_target_code[i] > CODE_LIMIT_4MHZ)
			else $error("limit flag without high code");
	end
endmodule
bind bsc_startup_cfg bsc_monitor u_mon (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .seq_slot_reached(seq_slot_reached),
	.hw_enable1(hw_enable1), .hw_enable2(hw_enable2), .buck_enable(buck_enable),
	.buck_target_code(buck_target_code), .buck_target_mv(buck_target_mv),
	.buck_limit_violation(buck_limit_violation));

// File: bsc_pkg.sv
// Purpose: Constants and types for the buck start-up configuration block
// Assumes: APB slave with 32-bit data, word-indexed register map
// Notes: Register byte address is four times its index

package bsc_pkg;

	// ----------------------------------------------------------------
	// Bus geometry
	// ----------------------------------------------------------------
	localparam int ADDR_W = 20;
	localparam int DATA_W = 32;
	localparam int IDX_W = 18;

	// ----------------------------------------------------------------
	// Register indices (byte address = index * 4)
	// ----------------------------------------------------------------
	localparam logic [IDX_W-1:0] CFG_IDX = 18'h07811;
	localparam logic [IDX_W-1:0] MODE_IDX = 18'h07820;
	localparam logic [IDX_W-1:0] STAT_IDX = 18'h07821;

	// ----------------------------------------------------------------
	// Start-up configuration fields and reset value
	// ----------------------------------------------------------------
	localparam logic [15:0] CFG_RST = 16'h0000;
	localparam int SECOND_SLOT_LSB = 13;
	localparam int SECOND_VOLT_LSB = 8;
	localparam int FIRST_SLOT_LSB = 5;
	localparam int FIRST_VOLT_LSB = 0;
	localparam int SLOT_W = 3;
	localparam int VOLT_W = 5;
	localparam int CODE_W = 7;
	localparam int MV_W = 11;

	// ----------------------------------------------------------------
	// Mode register: one 4 MHz switching flag per converter
	// ----------------------------------------------------------------
	localparam logic [1:0] MODE_RST = 2'h0;

	// ----------------------------------------------------------------
	// Status register layout
	// ----------------------------------------------------------------
	localparam int STAT_CODE0_LSB = 0;
	localparam int STAT_CODE1_LSB = 8;
	localparam int STAT_ENA_LSB = 16;
	localparam int STAT_LIMIT_LSB = 18;

	// ----------------------------------------------------------------
	// Slot codes
	// ----------------------------------------------------------------
	localparam logic [2:0] SLOT_OFF = 3'h0;
	localparam logic [2:0] SLOT_LAST = 3'h5;
	localparam logic [2:0] SLOT_HW1 = 3'h6;
	localparam logic [2:0] SLOT_HW2 = 3'h7;

	// ----------------------------------------------------------------
	// Voltage code map
	// ----------------------------------------------------------------
	localparam logic [6:0] CODE_FLOOR = 7'h08;
	localparam logic [6:0] CODE_CEIL = 7'h68;
	localparam logic [6:0] CODE_LIMIT_4MHZ = 7'h48;
	localparam logic [1:0] CODE_LOW_BITS = 2'h0;
	localparam int BASE_MV = 600;
	localparam int STEP_UV_X100 = 1250;
	localparam int COARSE_STEP_MV = 50;

	// ----------------------------------------------------------------
	// APB slave state, Gray coded
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		BSC_IDLE = 2'b00,
		BSC_ACCESS = 2'b01
	} bsc_state_t;

endpackage

// File: bsc_startup_cfg.sv
// Purpose: Start-up slot and voltage configuration for two buck converters
// Assumes: APB master; sequencer drives timeslot-reached levels
// Notes: One wait-free access phase; unmapped addresses answer with pslverr
//
// Local design decision: the APB register port.

`timescale 1ns/10ps

// Function
// - Bits 15:13 hold the second converter slot code, 000 disabled and 001 to 101 meaning timeslots one to five.
// - Slot code 110 gives the enable to hardware enable one and 111 to hardware enable two.
// - Bits 7:5 hold the first converter slot code with the same eight-value encoding.
// - Bits 12:8 are bits six to two of the second converter voltage code, 50 mV per step.
// - Bits 4:0 are bits six to two of the first converter voltage code, 50 mV per step.
// - Voltage codes up to 08h give 0.6 V, rise 12.5 mV per code, and saturate at 1.8 V from 68h.
module bsc_startup_cfg
	import bsc_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [bsc_pkg::ADDR_W-1:0] paddr,
	input wire logic [bsc_pkg::DATA_W-1:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [bsc_pkg::DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [4:0] seq_slot_reached,
	input wire logic hw_enable1,
	input wire logic hw_enable2,
	output logic [1:0] buck_enable,
	output logic [1:0][bsc_pkg::CODE_W-1:0] buck_target_code,
	output logic [1:0][bsc_pkg::MV_W-1:0] buck_target_mv,
	output logic [1:0] buck_limit_violation
);
	import bsc_pkg::*;

	// ----------------------------------------------------------------
	// Decoding functions
	// ----------------------------------------------------------------

	// Slot code to enable level
	function automatic logic slot_enable(input logic [2:0] slot, input logic [4:0] reached,
		input logic hw1, input logic hw2);
		logic en;
		en = 1'b0;
		if (slot == SLOT_HW1) begin
			en = hw1;
		end else if (slot == SLOT_HW2) begin
			en = hw2;
		end else if (slot != SLOT_OFF && slot <= SLOT_LAST) begin
			en = reached[slot - 3'h1];
		end
		return en;
	endfunction

	// Coarse field to full 7-bit code
	function automatic logic [6:0] full_code(input logic [4:0] coarse);
		return {coarse, CODE_LOW_BITS};
	endfunction

	// Full code to target millivolts
	function automatic logic [10:0] code_to_mv(input logic [6:0] code);
		logic [6:0] clip;
		int mv;
		clip = code;
		if (clip < CODE_FLOOR) begin
			clip = CODE_FLOOR;
		end
		if (clip > CODE_CEIL) begin
			clip = CODE_CEIL;
		end
		mv = BASE_MV + ((int'(clip) - int'(CODE_FLOOR)) * STEP_UV_X100) / 100;
		return mv[10:0];
	endfunction

	// Word index decode from byte address
	function automatic logic [IDX_W-1:0] word_index(input logic [ADDR_W-1:0] addr);
		return addr[ADDR_W-1:2];
	endfunction

	// ----------------------------------------------------------------
	// APB slave state
	// ----------------------------------------------------------------
	bsc_state_t state_ff;
	bsc_state_t nxt_state;
	logic [DATA_W-1:0] prdata_ff;
	logic [DATA_W-1:0] nxt_prdata;
	logic pready_ff;
	logic nxt_pready;
	logic pslverr_ff;
	logic nxt_pslverr;

	// ----------------------------------------------------------------
	// Register state
	// ----------------------------------------------------------------
	logic [15:0] cfg_ff;
	logic [15:0] nxt_cfg;
	logic [1:0] mode_ff;
	logic [1:0] nxt_mode;

	// ----------------------------------------------------------------
	// Derived per-converter state
	// ----------------------------------------------------------------
	logic [1:0] ena_ff;
	logic [1:0] nxt_ena;
	logic [1:0][CODE_W-1:0] code_ff;
	logic [1:0][CODE_W-1:0] nxt_code;
	logic [1:0][MV_W-1:0] mv_ff;
	logic [1:0][MV_W-1:0] nxt_mv;
	logic [1:0] limit_ff;
	logic [1:0] nxt_limit;
	logic [1:0] dec_ena;
	logic [1:0][CODE_W-1:0] dec_code;
	logic [1:0][MV_W-1:0] dec_mv;
	logic [1:0] dec_limit;

	logic [1:0][SLOT_W-1:0] slot_fld;
	logic [1:0][VOLT_W-1:0] volt_fld;
	logic [IDX_W-1:0] idx;
	logic hit_cfg;
	logic hit_mode;
	logic hit_stat;
	logic wr_commit;
	logic wr_cfg_lo;
	logic wr_cfg_hi;
	logic wr_mode;
	logic [DATA_W-1:0] stat_word;
	logic [DATA_W-1:0] rd_word;

	// Field extraction
	assign slot_fld[0] = cfg_ff[FIRST_SLOT_LSB +: SLOT_W];
	assign slot_fld[1] = cfg_ff[SECOND_SLOT_LSB +: SLOT_W];
	assign volt_fld[0] = cfg_ff[FIRST_VOLT_LSB +: VOLT_W];
	assign volt_fld[1] = cfg_ff[SECOND_VOLT_LSB +: VOLT_W];

	// Address decode
	assign idx = word_index(paddr);
	assign hit_cfg = (idx == CFG_IDX);
	assign hit_mode = (idx == MODE_IDX);
	assign hit_stat = (idx == STAT_IDX);
	assign wr_commit = psel && penable && pready_ff && pwrite;

	// Per-lane write strobes, taken at the access edge
	assign wr_cfg_lo = wr_commit && hit_cfg && pstrb[0];
	assign wr_cfg_hi = wr_commit && hit_cfg && pstrb[1];
	assign wr_mode = wr_commit && hit_mode && pstrb[0];

	// ----------------------------------------------------------------
	// Read data
	// ----------------------------------------------------------------

	// Status word from the registered decode
	always_comb begin
		stat_word = '0;
		stat_word[STAT_CODE0_LSB +: CODE_W] = code_ff[0];
		stat_word[STAT_CODE1_LSB +: CODE_W] = code_ff[1];
		stat_word[STAT_ENA_LSB +: 2] = ena_ff;
		stat_word[STAT_LIMIT_LSB +: 2] = limit_ff;
	end

	// Word of the addressed register, zero when unmapped
	always_comb begin
		rd_word = '0;
		if (hit_cfg) begin
			rd_word = {16'h0000, cfg_ff};
		end else if (hit_mode) begin
			rd_word = {30'h00000000, mode_ff};
		end else if (hit_stat) begin
			rd_word = stat_word;
		end
	end

	// ----------------------------------------------------------------
	// APB handshake
	// ----------------------------------------------------------------

	// Next answer: ready in the first access cycle
	always_comb begin
		nxt_state = state_ff;
		nxt_pready = 1'b0;
		nxt_pslverr = 1'b0;
		nxt_prdata = '0;
		case (state_ff)
			BSC_IDLE: begin
				if (psel && !penable) begin
					nxt_state = BSC_ACCESS;
					nxt_pready = 1'b1;
					nxt_pslverr = !(hit_cfg || hit_mode || hit_stat);
					if (!pwrite) begin
						nxt_prdata = rd_word;
					end
				end
			end
			BSC_ACCESS: begin
				nxt_state = BSC_IDLE;
			end
			default: begin
				nxt_state = BSC_IDLE;
			end
		endcase
	end

	// Register the answer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_ff <= BSC_IDLE;
			pready_ff <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff <= '0;
		end else begin
			state_ff <= nxt_state;
			pready_ff <= nxt_pready;
			pslverr_ff <= nxt_pslverr;
			prdata_ff <= nxt_prdata;
		end
	end

	// ----------------------------------------------------------------
	// Bus answer outputs
	// ----------------------------------------------------------------

	// Straight from the answer flops
	assign pready = pready_ff;
	assign pslverr = pslverr_ff;
	assign prdata = prdata_ff;

	// ----------------------------------------------------------------
	// Configuration and mode registers
	// ----------------------------------------------------------------

	// Byte-lane write of the writable registers
	always_comb begin
		nxt_cfg = cfg_ff;
		nxt_mode = mode_ff;
		if (wr_cfg_lo) begin
			nxt_cfg[7:0] = pwdata[7:0];
		end
		if (wr_cfg_hi) begin
			nxt_cfg[15:8] = pwdata[15:8];
		end
		if (wr_mode) begin
			nxt_mode = pwdata[1:0];
		end
	end

	// Hold the registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_ff <= CFG_RST;
			mode_ff <= MODE_RST;
		end else begin
			cfg_ff <= nxt_cfg;
			mode_ff <= nxt_mode;
		end
	end

	// ----------------------------------------------------------------
	// Per-converter start-up decode
	// ----------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_buck
			// Enable, target code, target voltage and mode check
			assign dec_ena[g] = slot_enable(slot_fld[g], seq_slot_reached, hw_enable1, hw_enable2);
			assign dec_code[g] = full_code(volt_fld[g]);
			assign dec_mv[g] = code_to_mv(dec_code[g]);
			assign dec_limit[g] = mode_ff[g] && (dec_code[g] > CODE_LIMIT_4MHZ);
		end
	endgenerate

	// Next values of the derived state
	always_comb begin
		nxt_ena = dec_ena;
		nxt_code = dec_code;
		nxt_mv = dec_mv;
		nxt_limit = dec_limit;
	end

	// Register decoded outputs
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ena_ff <= 2'h0;
			code_ff <= '0;
			mv_ff <= '0;
			limit_ff <= 2'h0;
		end else begin
			ena_ff <= nxt_ena;
			code_ff <= nxt_code;
			mv_ff <= nxt_mv;
			limit_ff <= nxt_limit;
		end
	end

	// ----------------------------------------------------------------
	// Converter outputs
	// ----------------------------------------------------------------

	// Straight from the decode flops
	assign buck_enable = ena_ff;
	assign buck_target_code = code_ff;
	assign buck_target_mv = mv_ff;
	assign buck_limit_violation = limit_ff;

endmodule

// File: test_bsc_startup_cfg.sv
// Purpose: Self-checking bench for the buck start-up block
// Assumes: Zero-wait APB slave, registered decode
// Notes: Inputs change by non-blocking assignment on the rising edge
`timescale 1ns/10ps
module test_bsc_startup_cfg;
	import bsc_pkg::*;
	localparam logic [19:0] A_CFG = {CFG_IDX, 2'h0};
	localparam logic [19:0] A_MODE = {MODE_IDX, 2'h0};
	localparam logic [19:0] A_STAT = {STAT_IDX, 2'h0};
	localparam logic [19:0] A_BAD = 20'h1E048;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic hw_enable1 = 1'b0, hw_enable2 = 1'b0, pready, pslverr, err;
	logic [19:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, rd;
	logic [3:0] pstrb = 4'hF;
	logic [4:0] seq_slot_reached = '0;
	logic [1:0] buck_enable, buck_limit_violation;
	logic [1:0][6:0] buck_target_code;
	logic [1:0][10:0] buck_target_mv;
	logic [4:0] vt [8] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h12, 5'h13, 5'h19, 5'h1A};
	int err_count = 0, comparisons = 0, cycles = 0;
	always #10 pclk = ~pclk;
	bsc_startup_cfg dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.seq_slot_reached(seq_slot_reached), .hw_enable1(hw_enable1), .hw_enable2(hw_enable2),
		.buck_enable(buck_enable), .buck_target_code(buck_target_code), .buck_target_mv(buck_target_mv),
		.buck_limit_violation(buck_limit_violation));
	// ----
	// Helpers
	// ----
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_count++;
			$display("unexpected at %0t: got %h want %h", $time, seen, exp);
		end
	endtask
	task automatic finish_test();
		$display("errors %0d comparisons %0d", err_count, comparisons);
		if (err_count == 0 && comparisons > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// One APB transfer; holds the request until ready is sampled
	task automatic xfer(input logic w, input logic [19:0] a, input logic [31:0] d, input logic [3:0] s);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) begin
			@(posedge pclk);
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic settle();
		repeat (2) @(posedge pclk);
	endtask
	function automatic logic [10:0] mv_of(input int c);
		if (c <= int'(CODE_FLOOR))
			return 11'h258;
		if (c >= int'(CODE_CEIL))
			return 11'h708;
		return 11'(600 + (c - 8) * 25 / 2);
	endfunction
	always @(posedge pclk) begin
		cycles++;
		if (cycles == 3000) begin
			err_count++;
			finish_test();
		end
	end
	// ----
	// Tests
	// ----
	initial begin
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		xfer(1'b0, A_CFG, '0, 4'hF);
		check(rd, 32'h0);
		check({buck_enable, buck_target_mv}, {2'h0, 11'h258, 11'h258});
		for (int k = 0; k < 2; k++) begin
			for (int c = 0; c < 8; c++) begin
				xfer(1'b1, A_CFG, 32'(c) << (k ? 13 : 5), 4'h3);
				seq_slot_reached <= (c inside {[1:5]}) ? 5'(1 << (c - 1)) : 5'h00;
				hw_enable1 <= (c == 6);
				hw_enable2 <= (c == 7);
				settle();
				check(buck_enable, (c != 0) ? 2'(1 << k) : 2'h0);
				seq_slot_reached <= ~seq_slot_reached;
				hw_enable1 <= ~hw_enable1;
				hw_enable2 <= ~hw_enable2;
				settle();
				check(buck_enable, 2'h0);
			end
		end
		foreach (vt[i]) begin
			xfer(1'b1, A_CFG, {16'h0, 3'h0, 5'(31 - vt[i]), 3'h0, vt[i]}, 4'h3);
			settle();
			check(buck_target_code, {5'(31 - vt[i]), 2'h0, vt[i], 2'h0});
			check(buck_target_mv, {mv_of(4 * (31 - vt[i])), mv_of(4 * vt[i])});
		end
		xfer(1'b1, A_MODE, 32'h3, 4'hF);
		xfer(1'b1, A_CFG, 32'h1312, 4'hF);
		settle();
		check(buck_limit_violation, 2'h2);
		xfer(1'b0, A_STAT, '0, 4'hF);
		check({err, rd}, {1'b0, 32'h00084C48});
		xfer(1'b1, A_MODE, 32'h1, 4'hF);
		xfer(1'b1, A_CFG, 32'h1313, 4'hF);
		settle();
		check(buck_limit_violation, 2'h1);
		xfer(1'b1, A_CFG, 32'h0, 4'hF);
		xfer(1'b1, A_CFG, 32'hFFFFFFFF, 4'h1);
		xfer(1'b0, A_CFG, '0, 4'hF);
		check(rd, 32'h000000FF);
		xfer(1'b1, A_CFG, 32'hFFFFFFFF, 4'hF);
		xfer(1'b0, A_CFG, '0, 4'hF);
		check(rd, 32'h0000FFFF);
		xfer(1'b1, A_BAD, 32'h0, 4'hF);
		check(err, 1'b1);
		xfer(1'b0, A_BAD, '0, 4'hF);
		check({err, rd}, {1'b1, 32'h0});
		xfer(1'b0, A_CFG, '0, 4'hF);
		check(rd, 32'h0000FFFF);
		finish_test();
	end
endmodule
